// ==== sim/wdt_monitor.sv ====
// Checker of watchdog bus handshake and output pulses
`timescale 1ns/10ps
`default_nettype none
module wdt_monitor
	import wdt_pkg::*;
(
	input wire logic		clk_i,			// clock
	input wire logic		rstn_i,			// reset
	input wire logic [1:0]	wdt_mode_cfg_i,		// mode
	input wire logic [3:0]	avs_address,		// address
	input wire logic		avs_read,		// read
	input wire logic		avs_write,		// write
	input wire logic [31:0]	avs_readdata,		// read data
	input wire logic		avs_waitrequest,	// stall
	input wire logic		sleep_o,		// asleep
	input wire logic		wdt_reset_o,		// reset pulse
	input wire logic		wake_o			// wake pulse
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	logic [2:0]	off_q;
	// Cycles spent in the off mode, saturating
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			off_q <= 3'h0;
		else if (wdt_mode_cfg_i != WDT_MODE_OFF)
			off_q <= 3'h0;
		else if (off_q != 3'h7)
			off_q <= off_q + 3'h1;
	end
	ack_delay_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("ack late");
	ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("ack too long");
	ack_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("ack without request");
	unmapped_read_a: assert property (!avs_waitrequest && avs_read
		&& avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0) else $error("unmapped data");
	rst_pulse_a: assert property (wdt_reset_o |=> !wdt_reset_o) else $error("reset pulse long");
	rst_awake_a: assert property (wdt_reset_o |-> !$past(sleep_o))
		else $error("reset while asleep");
	wake_sleep_a: assert property (wake_o |-> $past(sleep_o) && !sleep_o)
		else $error("wake not from sleep");
	off_quiet_a: assert property (off_q == 3'h7 |-> !wdt_reset_o)
		else $error("reset in off mode");
endmodule // wdt_monitor
bind wdt_top wdt_monitor mon_u (.clk_i, .rstn_i, .wdt_mode_cfg_i, .avs_address, .avs_read,
	.avs_write, .avs_readdata, .avs_waitrequest, .sleep_o, .wdt_reset_o, .wake_o);
`default_nettype wire

// ==== sim/wdt_top_tb.sv ====
// Self-checking bench of the sleep-aware watchdog
`timescale 1ns/10ps
`default_nettype none
module wdt_top_tb import wdt_pkg::*; ;
	logic		clk_i = 1'b0;
	logic		rstn_i = 1'b0;
	logic [1:0]	mode = WDT_MODE_OFF;
	logic		osc_fail = 1'b0, wake_ev = 1'b0, rd = 1'b0, wr = 1'b0;
	logic [3:0]	addr = 4'h0, fsel = 4'h0, be = 4'hF;
	logic [31:0]	wdata = 32'h0, rdata, q, d;
	logic		wreq, slp, wrst, wake;
	logic [5:0]	cur = {WDT_PS_RESET, WDT_EN_RESET};
	int		miscompares = 0, checked = 0, at_r, at_w;
	int		exp_t = WDT_LF_DIV * WDT_TICK_LF;
	always #50 clk_i = ~clk_i;
	wdt_top dut_u (.clk_i, .rstn_i, .wdt_mode_cfg_i(mode), .osc_fail_i(osc_fail),
		.wake_event_i(wake_ev), .internal_osc_clock_freq_sel_i(fsel), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
		.avs_waitrequest(wreq), .sleep_o(slp), .wdt_reset_o(wrst), .wake_o(wake));
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		checked++;
		if (got !== want) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask
	task automatic test_done;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] v);
		@(posedge clk_i);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= v;
		do begin
			@(posedge clk_i);
		end while (wreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] want);
		bus(a, 1'b0, 32'h0);
		chk(q & m, want);
	endtask
	task automatic watch(input int n);
		at_r = -1;
		at_w = -1;
		for (int i = 1; i <= n; i++) begin
			@(posedge clk_i);
			if (at_r < 0 && wrst === 1'b1)
				at_r = i;
			if (at_w < 0 && wake === 1'b1)
				at_w = i;
		end
	endtask
	function automatic logic near(input int at);
		return (at > exp_t - 30) && (at < exp_t + 30);
	endfunction
	initial begin
		#(9_500_000);
		miscompares++;
		test_done;
	end
	initial begin
		void'($urandom(96306));
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		rdc(WDT_OFF_CTRL, 32'hFFFFFFFF, {26'h0, cur});
		rdc(WDT_OFF_STATUS, 32'h3, 32'h3);
		rdc(WDT_OFF_POWER_CONTROL_REG, 32'h1, 32'h0);
		bus(4'h2, 1'b0, 32'h0);
		repeat (4) begin
			d = $urandom;
			be <= d[11:8];
			bus(WDT_OFF_CTRL, 1'b1, d);
			if (d[8])
				cur = d[5:0];
			rdc(WDT_OFF_CTRL, 32'h3F, {26'h0, cur});
		end
		be <= 4'hF;
		bus(WDT_OFF_CTRL, 1'b1, 32'h1);
		watch(10500);
		chk(32'(at_r), 32'hFFFFFFFF);
		mode <= WDT_MODE_SW;
		bus(WDT_OFF_CTRL, 1'b1, 32'h0);
		watch(10500);
		chk(32'(at_r), 32'hFFFFFFFF);
		bus(WDT_OFF_CTRL, 1'b1, 32'h1);
		watch(10500);
		chk(32'(near(at_r)), 32'h1);
		rdc(WDT_OFF_STATUS, 32'h3, 32'h1);
		rdc(WDT_OFF_POWER_CONTROL_REG, 32'h1, 32'h1);
		bus(WDT_OFF_POWER_CONTROL_REG, 1'b1, 32'h0);
		rdc(WDT_OFF_POWER_CONTROL_REG, 32'h1, 32'h0);
		mode <= WDT_MODE_ON;
		watch(6000);
		bus(WDT_OFF_CMD, 1'b1, 32'h1);
		watch(3000);
		fsel <= 4'($urandom);
		watch(8000);
		chk(32'(near(at_r + 3000)), 32'h1);
		bus(WDT_OFF_CMD, 1'b1, 32'h2);
		rdc(WDT_OFF_STATUS, 32'h1, 32'h0);
		chk({31'h0, slp}, 32'h1);
		watch(10500);
		chk(32'(near(at_w)), 32'h1);
		chk(32'(at_r), 32'hFFFFFFFF);
		mode <= WDT_MODE_AWAKE;
		bus(WDT_OFF_CMD, 1'b1, 32'h2);
		watch(10500);
		chk(32'(at_w), 32'hFFFFFFFF);
		wake_ev <= 1'b1;
		watch(8);
		wake_ev <= 1'b0;
		chk({31'h0, slp}, 32'h0);
		chk(32'(at_w > 0), 32'h1);
		osc_fail <= 1'b1;
		watch(10500);
		chk(32'(at_r), 32'hFFFFFFFF);
		test_done;
	end
endmodule // wdt_top_tb
`default_nettype wire

// ==== src/wdt_pkg.sv ====
// Package: watchdog register map, field layout, reset values and timing counts
package wdt_pkg;

	// ========================================
	// Register map (byte addresses, one word each)
	localparam logic [3:0] WDT_OFF_CTRL   = 4'h0;  // watchdog_control
	localparam logic [3:0] WDT_OFF_STATUS = 4'h4;  // timeout / powerdown flags
	localparam logic [3:0] WDT_OFF_POWER_CONTROL_REG   = 4'h8;  // power_control_reg cause flag
	localparam logic [3:0] WDT_OFF_CMD    = 4'hC;  // clear command, sleep requests

	// ========================================
	// Field positions
	localparam int WDT_CTRL_EN_BIT   = 0;   // sw_wdt_enable
	localparam int WDT_CTRL_PS_LSB   = 1;   // wdt_period_sel low bit
	localparam int WDT_STAT_PD_BIT   = 0;   // powerdown_flag
	localparam int WDT_STAT_TO_BIT   = 1;   // timeout_flag
	localparam int WDT_POWER_CONTROL_REG_RC_BIT   = 0;   // wdt_reset_cause_flag
	localparam int WDT_CMD_CLR_BIT   = 0;   // wdt_clear_instr
	localparam int WDT_CMD_SLEEP_BIT = 1;   // enter sleep

	// ========================================
	// Reset values
	localparam logic [4:0] WDT_PS_RESET = 5'h0B;  // 2^11 ms, nominal 2 s
	localparam logic       WDT_EN_RESET = 1'b0;

	// ========================================
	// Modes of the two-bit configuration
	typedef enum logic [1:0] {
		WDT_MODE_OFF   = 2'b00,
		WDT_MODE_SW    = 2'b01,
		WDT_MODE_AWAKE = 2'b10,
		WDT_MODE_ON    = 2'b11
	} wdt_mode_t;

	// ========================================
	// Timing
	localparam int WDT_CLK_HZ    = 10_000_000;
	localparam int WDT_LFOSC_HZ  = 31_000;        // low_freq_int_osc rate
	localparam int WDT_TICK_US   = 1000;          // base tick 1 ms
	localparam int WDT_LF_DIV    = WDT_CLK_HZ / WDT_LFOSC_HZ;
	localparam int WDT_TICK_LF   = (WDT_LFOSC_HZ * WDT_TICK_US) / 1_000_000;
	localparam int WDT_PS_MAX    = 18;            // 2^18 ms, nominal 262 s
	localparam int WDT_CNT_W     = 19;

endpackage : wdt_pkg

// ==== src/wdt_tick.sv ====
// Low-frequency oscillator model and 1 ms base tick divider
`timescale 1ns/10ps
`default_nettype none

module wdt_tick
	import wdt_pkg::*;
#(
	parameter int LF_DIV  = WDT_LF_DIV,
	parameter int TICK_LF = WDT_TICK_LF
) (
	input  wire logic clk_i,    // system clock
	input  wire logic rstn_i,   // async reset, active low
	input  wire logic run_i,    // count while high, else held cleared
	output logic      tick_o    // one-cycle 1 ms pulse
);

	typedef struct packed {
		logic [9:0] lf_cnt;
		logic [5:0] ms_cnt;
		logic       tick;
	} wdt_tick_st_t;

	wdt_tick_st_t s_q;
	wdt_tick_st_t s_d;

	// ========================================
	// Divider chain
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run_i) begin
			s_d.lf_cnt = '0;
			s_d.ms_cnt = '0;
		end else if (s_q.lf_cnt == 10'(LF_DIV - 1)) begin
			s_d.lf_cnt = '0;
			if (s_q.ms_cnt == 6'(TICK_LF - 1)) begin
				s_d.ms_cnt = '0;
				s_d.tick   = 1'b1;
			end else begin
				s_d.ms_cnt = s_q.ms_cnt + 6'h01;
			end
		end else begin
			s_d.lf_cnt = s_q.lf_cnt + 10'h001;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick_o = s_q.tick;

endmodule // wdt_tick

`default_nettype wire

// ==== src/wdt_top.sv ====
// Sleep-aware watchdog timer with Avalon-MM register slave
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

module wdt_top
	import wdt_pkg::*;
(
	input  wire logic        clk_i,              // system clock 10 MHz
	input  wire logic        rstn_i,             // async reset, active low
	input  wire logic [1:0]  wdt_mode_cfg_i,     // configuration mode bits
	input  wire logic        osc_fail_i,         // oscillator failure (async)
	input  wire logic        wake_event_i,       // other wake source (async)
	input  wire logic [3:0]  internal_osc_clock_freq_sel_i,  // divider select, unused by counter
	input  wire logic [3:0]  avs_address,        // byte address
	input  wire logic        avs_read,           // read strobe
	input  wire logic        avs_write,          // write strobe
	input  wire logic [31:0] avs_writedata,      // write data
	input  wire logic [3:0]  avs_byteenable,     // byte lanes
	output logic [31:0]      avs_readdata,       // read data
	output logic             avs_waitrequest,    // stall
	output logic             sleep_o,            // device asleep
	output logic             wdt_reset_o,        // one-cycle device reset pulse
	output logic             wake_o              // one-cycle wake pulse
);

	typedef struct packed {
		logic [1:0]           mode_s1;
		logic [1:0]           mode_s2;
		logic                 fail_s1;
		logic                 fail_s2;
		logic                 wake_s1;
		logic                 wake_s2;
		logic                 sw_en;
		logic [4:0]           ps;
		logic [WDT_CNT_W-1:0] cnt;
		logic                 sleep;
		logic                 to_flag;
		logic                 pd_flag;
		logic                 rc_flag;
		logic                 rst;
		logic                 wake;
		logic                 ack;
		logic [31:0]          rdata;
	} wdt_st_t;

	wdt_st_t s_q;
	wdt_st_t s_d;
	logic    tick;
	logic    active;
	logic    cmd_wr;
	logic    restart;

	// ========================================
	// Enable decode
	function automatic logic wdt_active(input logic [1:0] mode, input logic en,
	                                    input logic asleep);
		unique case (wdt_mode_t'(mode))
			WDT_MODE_ON:    wdt_active = 1'b1;
			WDT_MODE_AWAKE: wdt_active = !asleep;
			WDT_MODE_SW:    wdt_active = en;
			WDT_MODE_OFF:   wdt_active = 1'b0;
		endcase
	endfunction

	// Terminal count for period select, saturated at 2^18 ms, nominal 262 s
	function automatic logic [WDT_CNT_W-1:0] wdt_limit(input logic [4:0] sel);
		logic [4:0] e;
		e = (sel > 5'(WDT_PS_MAX)) ? 5'(WDT_PS_MAX) : sel;
		wdt_limit = WDT_CNT_W'(1) << e;
	endfunction

	assign active = wdt_active(s_q.mode_s2, s_q.sw_en, s_q.sleep);

	// Restart of counter and 1 ms divider, so a clear always buys a full period
	assign cmd_wr  = avs_write && !s_q.ack && avs_byteenable[0]
	                 && (avs_address == WDT_OFF_CMD);
	assign restart = (cmd_wr && avs_writedata[WDT_CMD_CLR_BIT])
	                 || (cmd_wr && avs_writedata[WDT_CMD_SLEEP_BIT] && !s_q.sleep)
	                 || s_q.fail_s2
	                 || (s_q.sleep && s_q.wake_s2);

	wdt_tick u_tick (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.run_i  (active && !restart),
		.tick_o (tick)
	);

	// ========================================
	// Next state
	always_comb begin
		logic wr;
		logic rd;
		logic clr_cmd;
		logic sleep_req;
		logic timeout;
		wr = 1'b0;
		rd = 1'b0;
		clr_cmd = 1'b0;
		sleep_req = 1'b0;
		timeout = 1'b0;
		s_d = s_q;
		s_d.mode_s1 = wdt_mode_cfg_i;
		s_d.mode_s2 = s_q.mode_s1;
		s_d.fail_s1 = osc_fail_i;
		s_d.fail_s2 = s_q.fail_s1;
		s_d.wake_s1 = wake_event_i;
		s_d.wake_s2 = s_q.wake_s1;
		s_d.rst  = 1'b0;
		s_d.wake = 1'b0;
		s_d.ack  = 1'b0;

		wr = avs_write && !s_q.ack;
		rd = avs_read && !s_q.ack;
		if (wr || rd) begin
			s_d.ack = 1'b1;
		end

		if (wr && avs_byteenable[0]) begin
			unique case (avs_address)
				WDT_OFF_CTRL: begin
					s_d.sw_en = avs_writedata[WDT_CTRL_EN_BIT];
					s_d.ps    = avs_writedata[WDT_CTRL_PS_LSB +: 5];
				end
				WDT_OFF_POWER_CONTROL_REG: begin
					if (!avs_writedata[WDT_POWER_CONTROL_REG_RC_BIT]) begin
						s_d.rc_flag = 1'b0;
					end
				end
				WDT_OFF_CMD: begin
					clr_cmd   = avs_writedata[WDT_CMD_CLR_BIT];
					sleep_req = avs_writedata[WDT_CMD_SLEEP_BIT];
				end
				default: ;
			endcase
		end

		if (rd) begin
			s_d.rdata = '0;
			unique case (avs_address)
				WDT_OFF_CTRL: begin
					s_d.rdata[WDT_CTRL_EN_BIT]       = s_q.sw_en;
					s_d.rdata[WDT_CTRL_PS_LSB +: 5]  = s_q.ps;
				end
				WDT_OFF_STATUS: begin
					s_d.rdata[WDT_STAT_PD_BIT] = s_q.pd_flag;
					s_d.rdata[WDT_STAT_TO_BIT] = s_q.to_flag;
				end
				WDT_OFF_POWER_CONTROL_REG: s_d.rdata[WDT_POWER_CONTROL_REG_RC_BIT] = s_q.rc_flag;
				default: ;
			endcase
		end

		// Clear command sets both status flags high, as a clear instruction does
		if (clr_cmd) begin
			s_d.to_flag = 1'b1;
			s_d.pd_flag = 1'b1;
		end
		// Sleep entry: powerdown flag low
		if (sleep_req && !s_q.sleep) begin
			s_d.sleep   = 1'b1;
			s_d.pd_flag = 1'b0;
		end

		// Counter; internal_osc_clock_freq_sel_i deliberately not used here
		timeout = active && tick && (s_q.cnt + WDT_CNT_W'(1) >= wdt_limit(s_q.ps));
		// Wake ends Sleep even while the counter is disabled
		if (s_q.sleep && s_q.wake_s2) begin
			s_d.sleep = 1'b0;
			s_d.wake  = 1'b1;
		end
		if (!active || restart) begin
			s_d.cnt = '0;
		end else if (timeout) begin
			s_d.cnt     = '0;
			s_d.to_flag = 1'b0;
			s_d.rc_flag = 1'b1;
			if (s_q.sleep) begin
				s_d.sleep = 1'b0;
				s_d.wake  = 1'b1;
			end else begin
				s_d.rst = 1'b1;
			end
		end else if (tick) begin
			s_d.cnt = s_q.cnt + WDT_CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_q         <= '0;
			s_q.ps      <= WDT_PS_RESET;
			s_q.sw_en   <= WDT_EN_RESET;
			s_q.to_flag <= 1'b1;
			s_q.pd_flag <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign avs_readdata    = s_q.rdata;
	assign avs_waitrequest = !s_q.ack;
	assign sleep_o         = s_q.sleep;
	assign wdt_reset_o     = s_q.rst;
	assign wake_o          = s_q.wake;

endmodule // wdt_top

`default_nettype wire
